// [src/dynamic_fan_threshold_adjust.v]
// Dynamic fan start temperature adjustment for two remote zones
`timescale 1ns/1ps
`default_nettype none
`include "fan_adjust_consts.vh"

// Overview of operation
// - Temperature below low limit makes the start temperature eligible for raising.
// - Temperature below low limit sets a sticky error flag and alert.
// - Temperature above high limit sets a sticky error flag and alert.
// - Decrease pass every n monitoring cycles, increase pass every 2n.
// - Period codes: zone 1 in bits 2:0, zone 2 in bits 5:3.
// - Short period is 8 shifted by code; long period is twice that.
// - Above target minus hysteresis, lower start by 2 per degree of rise.
// - Rise of a quarter degree or less leaves start unchanged on decrease pass.
// - Above target, each long pass lowers start by one more degree.
// - Between target minus hysteresis and target, long pass adds no decrement; it may still raise below low limit.
// - Between low limit and target minus hysteresis, start is held.
// - Raise only if below low, start below high and target, temp above start.
// - A raise never takes the adjusted start above the zone high limit.
// - Adjusted start never goes below minus 64 degrees.
// - Below the start temperature, adjustment for that zone is suspended.
// - Control one bits 1:0 switch adjustment per zone.
// - Bit 0 is zone 1, bit 1 zone 2; zero leaves start unadjusted.
// - Each zone has an 8-bit target, one degree steps, reset 100 degrees.
// - Hysteresis field in bits 7:4, reset 4 degrees.
module dynamic_fan_threshold_adjust
(
  // Clock and reset
  input  wire                        clock,
  input  wire                        rst,
  // Register port
  input  wire                        reg_wr,
  input  wire                        reg_rd,
  input  wire [7:0]                  reg_addr,
  input  wire [7:0]                  reg_wdata,
  output reg  [7:0]                  reg_rdata,
  // Monitoring timebase and measurements, zone 2 in upper half
  input  wire                        monitor_tick,
  input  wire [2*`ADJ_TEMP_W-1:0]    zone_temperature,
  input  wire [15:0]                 zone_low_limit,
  input  wire [15:0]                 zone_high_limit,
  // Results, zone 2 in upper half
  output wire [15:0]                 fan_start_temperature,
  output wire [3:0]                  limit_error_flags,
  output wire                        limit_alert
);

  reg  [7:0] control_one_r;
  reg  [7:0] period_select_r;
  reg  [7:0] hyst_r;
  reg  [3:0] status_r;
  wire [3:0] status_set;
  wire [3:0] status_clr;
  wire [7:0] target_bus [0:1];
  wire [7:0] start_bus  [0:1];

  assign status_clr            = (reg_rd && reg_addr == `ADJ_STATUS_ADDR) ? 4'hf : 4'h0;
  assign limit_error_flags     = status_r;
  assign limit_alert           = |status_r;
  assign fan_start_temperature = {start_bus[1], start_bus[0]};

  // Shared control registers
  always @(posedge clock)
  begin
    if (rst)
    begin
      control_one_r   <= `ADJ_CONTROL_ONE_RST;
      period_select_r <= `ADJ_PERIOD_SELECT_RST;
      hyst_r          <= `ADJ_HYST_RST;
    end
    else if (reg_wr)
    begin
      case (reg_addr)
        `ADJ_CONTROL_ONE_ADDR:
          control_one_r <= reg_wdata & `ADJ_CONTROL_MASK;
        `ADJ_PERIOD_SELECT_ADDR:
          period_select_r <= reg_wdata & `ADJ_PERIOD_MASK;
        `ADJ_HYST_ADDR:
          hyst_r <= reg_wdata;
        default:
          hyst_r <= hyst_r;
      endcase
    end
  end

  // Sticky limit flags; a new event in the clearing read wins
  always @(posedge clock)
  begin
    if (rst)
      status_r <= 4'h0;
    else
      status_r <= (status_r & ~status_clr) | status_set;
  end

  // Read data, registered
  always @(posedge clock)
  begin
    if (rst)
      reg_rdata <= 8'h00;
    else if (reg_rd)
    begin
      case (reg_addr)
        `ADJ_CONTROL_ONE_ADDR:   reg_rdata <= control_one_r;
        `ADJ_PERIOD_SELECT_ADDR: reg_rdata <= period_select_r;
        `ADJ_STATUS_ADDR:        reg_rdata <= {4'h0, status_r};
        `ADJ_START_Z1_ADDR:      reg_rdata <= start_bus[0];
        `ADJ_START_Z2_ADDR:      reg_rdata <= start_bus[1];
        `ADJ_TARGET_Z1_ADDR:     reg_rdata <= target_bus[0];
        `ADJ_TARGET_Z2_ADDR:     reg_rdata <= target_bus[1];
        `ADJ_HYST_ADDR:          reg_rdata <= hyst_r;
        default:                 reg_rdata <= 8'h00;
      endcase
    end
  end

  genvar z;
  generate
    for (z = 0; z < 2; z = z + 1)
    begin : zone
      wire                    short_pass;
      wire                    long_pass;
      wire [`ADJ_TEMP_W-1:0]  temp;
      wire [7:0]              low_lim;
      wire [7:0]              high_lim;
      wire [`ADJ_TEMP_W-1:0]  low_q;
      wire [`ADJ_TEMP_W-1:0]  high_q;
      wire [`ADJ_TEMP_W-1:0]  target_q;
      wire [`ADJ_TEMP_W-1:0]  start_q;
      wire [`ADJ_TEMP_W-1:0]  hyst_q;
      wire [`ADJ_TEMP_W-1:0]  band_q;
      wire [`ADJ_TEMP_W-1:0]  diff;
      wire                    enabled;
      wire                    below_low;
      wire                    above_high;
      wire                    above_band;
      wire                    above_target;
      wire                    active;
      wire                    may_raise;
      wire [8:0]              short_dec;
      wire [8:0]              total_dec;
      wire [8:0]              lowered;
      wire [8:0]              raised;
      wire [7:0]              adjusted;
      wire [7:0]              start_addr;
      wire [7:0]              target_addr;
      reg  [`ADJ_TEMP_W-1:0]  prev_temp_r;
      reg  [`ADJ_TEMP_W-1:0]  rise_r;
      reg  [7:0]              target_r;
      reg  [7:0]              start_r;

      zone_pass_timer timer
      (
        .clock        (clock),
        .rst          (rst),
        .monitor_tick (monitor_tick),
        .period_code  (period_select_r[z*`ADJ_CODE_W +: `ADJ_CODE_W]),
        .short_pass   (short_pass),
        .long_pass    (long_pass)
      );

      assign temp        = zone_temperature[z*`ADJ_TEMP_W +: `ADJ_TEMP_W];
      assign low_lim     = zone_low_limit[z*8 +: 8];
      assign high_lim    = zone_high_limit[z*8 +: 8];
      assign low_q       = {low_lim, {`ADJ_FRAC_W{1'b0}}};
      assign high_q      = {high_lim, {`ADJ_FRAC_W{1'b0}}};
      assign target_q    = {target_r, {`ADJ_FRAC_W{1'b0}}};
      assign start_q     = {start_r, {`ADJ_FRAC_W{1'b0}}};
      assign hyst_q      = {{(`ADJ_TEMP_W-`ADJ_HYST_W-`ADJ_FRAC_W){1'b0}},
                            hyst_r[`ADJ_HYST_LSB +: `ADJ_HYST_W], {`ADJ_FRAC_W{1'b0}}};
      // Target below hysteresis saturates at the bottom of the scale
      assign band_q      = (target_q > hyst_q) ? target_q - hyst_q : {`ADJ_TEMP_W{1'b0}};
      assign start_addr  = (z == 0) ? `ADJ_START_Z1_ADDR : `ADJ_START_Z2_ADDR;
      assign target_addr = (z == 0) ? `ADJ_TARGET_Z1_ADDR : `ADJ_TARGET_Z2_ADDR;

      assign enabled      = control_one_r[z];
      assign below_low    = temp < low_q;
      assign above_high   = temp > high_q;
      assign above_band   = temp > band_q;
      assign above_target = temp > target_q;
      assign active       = enabled && (temp >= start_q);
      assign may_raise    = below_low && (start_r < high_lim) &&
                            (start_r < target_r) && (temp > start_q);

      // Rise in quarter degrees: two degrees per degree of rise is rise/2
      assign short_dec = (above_band && rise_r > `ADJ_RISE_DEADBAND)
                         ? {1'b0, rise_r[8:1]} : 9'h000;
      assign total_dec = short_dec + {8'h00, long_pass && above_target};
      assign lowered   = ({1'b0, start_r} > total_dec)
                         ? {1'b0, start_r} - total_dec
                         : {1'b0, `ADJ_START_FLOOR};
      assign raised    = {1'b0, start_r} + 9'h001;

      // A raise needs total_dec of zero, so a decrease in the same pass wins over it
      assign adjusted = (long_pass && may_raise && total_dec == 9'h000)
                        ? ((raised[7:0] > high_lim) ? high_lim : raised[7:0])
                        : lowered[7:0];

      assign status_set[2*z]     = monitor_tick && below_low;
      assign status_set[2*z + 1] = monitor_tick && above_high;
      assign target_bus[z]       = target_r;
      assign start_bus[z]        = start_r;

      // Rise since the previous monitoring sample, falls clamp to zero
      always @(posedge clock)
      begin
        if (rst)
        begin
          prev_temp_r <= {`ADJ_TEMP_W{1'b0}};
          rise_r      <= {`ADJ_TEMP_W{1'b0}};
        end
        else if (monitor_tick)
        begin
          prev_temp_r <= temp;
          rise_r      <= (temp > prev_temp_r) ? temp - prev_temp_r
                                              : {`ADJ_TEMP_W{1'b0}};
        end
      end

      // Target register
      always @(posedge clock)
      begin
        if (rst)
          target_r <= `ADJ_TARGET_RST;
        else if (reg_wr && reg_addr == target_addr)
          target_r <= reg_wdata;
      end

      // Start temperature: software write wins over a pass in the same cycle
      always @(posedge clock)
      begin
        if (rst)
          start_r <= `ADJ_START_RST;
        else if (reg_wr && reg_addr == start_addr)
          start_r <= reg_wdata;
        else if (short_pass && active)
          start_r <= adjusted;
      end
    end
  endgenerate

endmodule
`default_nettype wire

// [src/fan_adjust_consts.vh]
// Constants for the zone fan start temperature adjuster
`ifndef FAN_ADJUST_CONSTS_VH
`define FAN_ADJUST_CONSTS_VH

// Register offsets
`define ADJ_CONTROL_ONE_ADDR     8'h0b
`define ADJ_PERIOD_SELECT_ADDR   8'h0c
`define ADJ_STATUS_ADDR          8'h0d
`define ADJ_START_Z1_ADDR        8'h0e
`define ADJ_START_Z2_ADDR        8'h0f
`define ADJ_TARGET_Z1_ADDR       8'h5a
`define ADJ_TARGET_Z2_ADDR       8'h5b
`define ADJ_HYST_ADDR            8'h64

// Reset values
`define ADJ_CONTROL_ONE_RST      8'h00
`define ADJ_PERIOD_SELECT_RST    8'h00
`define ADJ_TARGET_RST           8'ha4
`define ADJ_HYST_RST             8'h40
`define ADJ_START_RST            8'h5a

// Field positions
`define ADJ_EN_Z1_BIT            0
`define ADJ_EN_Z2_BIT            1
`define ADJ_CODE_Z1_LSB          0
`define ADJ_CODE_Z2_LSB          3
`define ADJ_CODE_W               3
`define ADJ_HYST_LSB             4
`define ADJ_HYST_W               4
`define ADJ_PERIOD_MASK          8'h3f
`define ADJ_CONTROL_MASK         8'h03

// Temperature encoding: 8-bit code, offset 64, measured value has 2 fraction bits
`define ADJ_FRAC_W               2
`define ADJ_TEMP_W               10
`define ADJ_START_FLOOR          8'h00
`define ADJ_RISE_DEADBAND        10'h001

// Pass timing in monitoring cycles: short = 8 << code, long = 2 * short
`define ADJ_SHORT_BASE           11'h008
`define ADJ_CNT_W                11

`endif

// [src/zone_pass_timer.v]
// Short and long pass strobes for one zone, counted in monitoring cycles
`timescale 1ns/1ps
`default_nettype none
`include "fan_adjust_consts.vh"

module zone_pass_timer
(
  // Clock and reset
  input  wire                     clock,
  input  wire                     rst,
  // Timebase and period code
  input  wire                     monitor_tick,
  input  wire [`ADJ_CODE_W-1:0]   period_code,
  // Pass strobes
  output reg                      short_pass,
  output reg                      long_pass
);

  reg  [`ADJ_CNT_W-1:0] tick_cnt_r;
  reg                   half_r;
  wire [`ADJ_CNT_W-1:0] short_len;
  wire                  period_done;

  assign short_len   = `ADJ_SHORT_BASE << period_code;
  // Comparing with >= lets a shorter code take effect at once
  assign period_done = (tick_cnt_r + 11'h001) >= short_len;

  always @(posedge clock)
  begin
    if (rst)
    begin
      tick_cnt_r <= {`ADJ_CNT_W{1'b0}};
      half_r     <= 1'b0;
      short_pass <= 1'b0;
      long_pass  <= 1'b0;
    end
    else
    begin
      short_pass <= 1'b0;
      long_pass  <= 1'b0;
      if (monitor_tick)
      begin
        if (period_done)
        begin
          tick_cnt_r <= {`ADJ_CNT_W{1'b0}};
          half_r     <= ~half_r;
          short_pass <= 1'b1;
          long_pass  <= half_r;
        end
        else
        begin
          tick_cnt_r <= tick_cnt_r + 11'h001;
        end
      end
    end
  end

endmodule
`default_nettype wire

// [sim/fan_adjust_sva.sv]
// Assertion checker for the zone fan start temperature adjuster
`timescale 1ns/1ps
`default_nettype none
`include "fan_adjust_consts.vh"
module fan_adjust_sva
(
  // Clock and reset
  input wire logic        clock,
  input wire logic        rst,
  // Register port
  input wire logic        reg_wr,
  input wire logic        reg_rd,
  input wire logic [7:0]  reg_addr,
  input wire logic [7:0]  reg_wdata,
  input wire logic [7:0]  reg_rdata,
  // Zone side
  input wire logic        monitor_tick,
  input wire logic [19:0] zone_temperature,
  input wire logic [15:0] zone_low_limit,
  input wire logic [15:0] zone_high_limit,
  input wire logic [15:0] fan_start_temperature,
  input wire logic [3:0]  limit_error_flags,
  input wire logic        limit_alert
);
  default clocking @(posedge clock); endclocking
  default disable iff (rst);
  logic [1:0] en_r;
  wire  [9:0] t1 = zone_temperature[9:0];
  wire  [7:0] s1 = fan_start_temperature[7:0];
  // Enables shadowed from bus writes, since only ports are visible here
  always @(posedge clock)
    if (rst)
      en_r <= 2'b00;
    else if (reg_wr && reg_addr == `ADJ_CONTROL_ONE_ADDR)
      en_r <= reg_wdata[1:0];
  AST_ALERT_OR: assert property (limit_alert == |limit_error_flags)
    else $error("alert mismatch");
  AST_Z1_LOW: assert property (monitor_tick && t1 < {zone_low_limit[7:0], 2'b00}
    |=> limit_error_flags[0]) else $error("zone 1 low flag missing");
  AST_Z1_HIGH: assert property (monitor_tick && t1 > {zone_high_limit[7:0], 2'b00}
    |=> limit_error_flags[1]) else $error("zone 1 high flag missing");
  AST_Z2_LOW: assert property (monitor_tick
    && zone_temperature[19:10] < {zone_low_limit[15:8], 2'b00}
    |=> limit_error_flags[2]) else $error("zone 2 low flag missing");
  AST_QUIET: assert property (!$past(monitor_tick, 2) && !$past(reg_wr)
    |-> $stable(fan_start_temperature)) else $error("start moved outside a pass");
  AST_EN_OFF: assert property (!en_r[0] && !$past(reg_wr) |-> $stable(s1))
    else $error("disabled start moved");
  AST_SUSPEND: assert property (monitor_tick && t1 < {s1, 2'b00} ##1 !reg_wr
    |=> $stable(s1)) else $error("start moved while suspended");
  AST_RAISE: assert property (s1 > $past(s1) && !$past(reg_wr)
    |-> s1 == $past(s1) + 8'h01 && s1 <= zone_high_limit[7:0]) else $error("bad raise");
  AST_CTRL_RD: assert property (reg_rd && !reg_wr && reg_addr == `ADJ_CONTROL_ONE_ADDR
    |=> reg_rdata == {6'h00, en_r}) else $error("enable readback wrong");
  cover property (s1 < $past(s1));
  cover property (s1 > $past(s1));
  cover property ($rose(limit_alert));
endmodule
bind dynamic_fan_threshold_adjust fan_adjust_sva u_sva
(
  .clock(clock), .rst(rst), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
  .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .monitor_tick(monitor_tick),
  .zone_temperature(zone_temperature), .zone_low_limit(zone_low_limit),
  .zone_high_limit(zone_high_limit), .fan_start_temperature(fan_start_temperature),
  .limit_error_flags(limit_error_flags), .limit_alert(limit_alert)
);
`default_nettype wire

// [sim/dynamic_fan_threshold_adjust_tb_top.sv]
// Self-checking bench for the zone fan start temperature adjuster
`timescale 1ns/1ps
`default_nettype none
module dynamic_fan_threshold_adjust_tb_top;
  logic        clock = 1'b0;
  logic        rst = 1'b1;
  logic        reg_wr = 1'b0;
  logic        reg_rd = 1'b0;
  logic [7:0]  reg_addr = 8'h00;
  logic [7:0]  reg_wdata = 8'h00;
  logic        monitor_tick = 1'b0;
  logic [19:0] zone_temperature = 20'h0_0000;
  logic [15:0] zone_low_limit = 16'h0000;
  logic [15:0] zone_high_limit = 16'h00a0;
  wire  [7:0]  reg_rdata;
  wire  [15:0] fan_start_temperature;
  wire  [3:0]  limit_error_flags;
  wire         limit_alert;
  integer      errors = 0;
  integer      comparisons = 0;
  integer      seed = 32'h0000_4634;
  integer      groups = 0;
  integer      per = 8;
  integer      exp1 = 90;
  integer      en1 = 1;
  integer      lo = 0;
  integer      hi = 160;
  always #2 clock = ~clock;
  dynamic_fan_threshold_adjust u_dut
  (
    .clock(clock), .rst(rst), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .monitor_tick(monitor_tick),
    .zone_temperature(zone_temperature), .zone_low_limit(zone_low_limit),
    .zone_high_limit(zone_high_limit), .fan_start_temperature(fan_start_temperature),
    .limit_error_flags(limit_error_flags), .limit_alert(limit_alert)
  );
  task automatic chk(input logic [7:0] seen, input logic [7:0] expv);
    comparisons = comparisons + 1;
    if (seen !== expv)
    begin
      errors = errors + 1;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, expv);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clock);
    reg_wr = 1'b1;
    reg_addr = a;
    reg_wdata = d;
    @(negedge clock);
    reg_wr = 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    @(negedge clock);
    reg_rd = 1'b1;
    reg_addr = a;
    @(negedge clock);
    reg_rd = 1'b0;
    chk(reg_rdata, e);
  endtask
  task automatic lim(input logic [7:0] l, input logic [7:0] h);
    @(negedge clock);
    zone_low_limit[7:0] = l;
    zone_high_limit[7:0] = h;
    lo = l;
    hi = h;
  endtask
  // Target 128 and hysteresis 4 stay at these values for the whole run
  function automatic integer model(input integer s, input integer t, input integer lng,
                                   input integer d);
    integer v;
    begin
      v = s;
      if (en1 && t >= s * 4)
      begin
        if (t > 124 * 4 && d > 1) v = v - d / 2;
        if (lng && t > 128 * 4) v = v - 1;
        if (lng && v == s && t < lo * 4 && s < hi && s < 128 && t > s * 4) v = s + 1;
        if (v < 0) v = 0;
      end
      model = v;
    end
  endfunction
  // One pass: only the last tick steps, so the stored rise is exactly d quarters
  task automatic grp(input integer base, input integer d);
    integer k;
    integer t;
    integer r;
    begin
      for (k = 1; k <= per; k = k + 1)
      begin
        t = (k == per) ? base + d : base;
        r = $random(seed);
        @(negedge clock);
        zone_temperature = {r[9:0], t[9:0]};
        monitor_tick = 1'b1;
        @(negedge clock);
        monitor_tick = 1'b0;
        repeat (3) @(negedge clock);
      end
      groups = groups + 1;
      exp1 = model(exp1, base + d, groups % 2 == 0, d);
      chk(fan_start_temperature[7:0], exp1[7:0]);
      // Zone 2 is disabled before any tick, so its random temperatures must leave it alone
      chk(fan_start_temperature[15:8], 8'h5a);
    end
  endtask
  task automatic give_verdict;
    $display("errors %0d comparisons %0d", errors, comparisons);
    if (errors == 0 && comparisons > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  initial
  begin
    repeat (8) @(negedge clock);
    rst = 1'b0;
    rd(8'h0b, 8'h00);
    rd(8'h0c, 8'h00);
    rd(8'h5a, 8'ha4);
    rd(8'h5b, 8'ha4);
    rd(8'h64, 8'h40);
    rd(8'h0f, 8'h5a);
    rd(8'h10, 8'h00);
    wr(8'h0b, 8'hff);
    rd(8'h0b, 8'h03);
    wr(8'h0c, 8'hff);
    rd(8'h0c, 8'h3f);
    wr(8'h0c, 8'h00);
    wr(8'h0b, 8'h01);
    wr(8'h5a, 8'h80);
    grp(500, 2);
    grp(500, 7);
    grp(480, 7);
    grp(520, 0);
    grp(500, 1);
    grp(500, 0);
    repeat (4) grp(500, $random(seed) & 7);
    wr(8'h0c, 8'h01);
    per = 16;
    grp(500, 6);
    grp(500, 0);
    wr(8'h0e, 8'h5a);
    exp1 = 90;
    lim(8'h90, 8'h5b);
    repeat (4) grp(500, 0);
    chk({6'h00, limit_error_flags[1:0]}, 8'h03);
    lim(8'h00, 8'ha0);
    // Zone 2 limits stay at zero, so its random temperatures raise its high flag
    rd(8'h0d, 8'h0b);
    rd(8'h0d, 8'h00);
    wr(8'h0e, 8'h01);
    exp1 = 1;
    grp(500, 7);
    wr(8'h0e, 8'h7f);
    exp1 = 127;
    grp(500, 7);
    wr(8'h0b, 8'h00);
    en1 = 0;
    grp(500, 7);
    give_verdict;
  end
  initial
  begin
    repeat (20000) @(posedge clock);
    errors = errors + 1;
    give_verdict;
  end
endmodule
`default_nettype wire
